// ==== pdm_pkg.sv ====
// Package: register map, field positions, modes and clock codes for power-down control
package pdm_pkg;

    // Register byte addresses on the Wishbone slave
    localparam logic [3:0] PDM_ADDR_PWR = 4'h0;
    localparam logic [3:0] PDM_ADDR_MST = 4'h4;
    localparam logic [3:0] PDM_ADDR_SYS = 4'h8;
    localparam logic [3:0] PDM_ADDR_STAT = 4'hC;

    // Power mode / clock control fields
    localparam int PDM_SLEEP_KIND_POS = 7;
    localparam int PDM_DIRECT_POS = 5;
    localparam int PDM_DIV_LSB = 2;
    localparam logic [7:0] PDM_PWR_WMASK = 8'hBC;
    localparam logic [7:0] PDM_PWR_RESET = 8'h00;

    // Module stop fields
    localparam int PDM_STOP_I2C_POS = 6;
    localparam int PDM_STOP_SER_POS = 5;
    localparam int PDM_STOP_ADC_POS = 4;
    localparam int PDM_STOP_WDT_POS = 3;
    localparam int PDM_STOP_TW_POS = 2;
    localparam int PDM_STOP_TV_POS = 1;
    localparam logic [7:0] PDM_MST_WMASK = 8'h7E;
    localparam logic [7:0] PDM_MST_RESET = 8'h00;

    // System control: standby select and watchdog clock source
    localparam int PDM_STANDBY_POS = 7;
    localparam int PDM_WDT_OSC_POS = 0;
    localparam logic [7:0] PDM_SYS_WMASK = 8'h81;
    localparam logic [7:0] PDM_SYS_RESET = 8'h00;

    // Applied divide code after reset: undivided
    localparam logic [2:0] PDM_DIV_RESET = 3'h0;

    typedef enum logic [2:0] {
        PDM_MODE_ACTIVE = 3'h0,
        PDM_MODE_SLEEP = 3'h1,
        PDM_MODE_SUBSLEEP = 3'h3,
        PDM_MODE_STANDBY = 3'h2
    } pdm_mode_e;

    typedef struct packed {
        logic i2c;
        logic serial;
        logic adc;
        logic watchdog;
        logic timer_w;
        logic timer_v;
    } pdm_stop_s;

    // Ratio log2 of the applied divide code; 0 = undivided
    function automatic logic [2:0] pdm_div_shift(input logic [2:0] code);
        logic [2:0] r;
        r = 3'h0;
        case (code)
            3'h4: r = 3'h3;
            3'h5: r = 3'h4;
            3'h6: r = 3'h5;
            default: r = 3'h0;
        endcase
        return r;
    endfunction

endpackage

// ==== pdm_power_ctrl.sv ====
// Power-down mode selection, active clock divider and module-stop control
`timescale 1ns/10ps
module pdm_power_ctrl
    import pdm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic sleep_exec_i,
    input wire logic wake_i,
    output pdm_mode_e mode_o,
    output logic [2:0] div_shift_o,
    output logic clk_div_en_o,
    output pdm_stop_s clk_en_o
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] pwr_reg;
    logic [7:0] mst_reg;
    logic [7:0] sys_reg;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] next_pwr;
    logic [7:0] next_mst;
    logic [7:0] next_sys;
    logic next_ack;
    logic [31:0] next_rdata;
    logic wr_hit;

    assign wr_hit = cyc_i && stb_i && we_i && !ack && sel_i[0];

    always_comb begin
        next_pwr = pwr_reg;
        next_mst = mst_reg;
        next_sys = sys_reg;
        next_ack = cyc_i && stb_i && !ack;
        next_rdata = 32'h0000_0000;
        if (wr_hit) begin
            case (adr_i)
                PDM_ADDR_PWR: next_pwr = dat_i[7:0] & PDM_PWR_WMASK;
                PDM_ADDR_MST: next_mst = dat_i[7:0] & PDM_MST_WMASK;
                PDM_ADDR_SYS: next_sys = dat_i[7:0] & PDM_SYS_WMASK;
                default: ;
            endcase
        end
        if (cyc_i && stb_i && !we_i && !ack) begin
            case (adr_i)
                PDM_ADDR_PWR: next_rdata = {24'h00_0000, pwr_reg & PDM_PWR_WMASK};
                PDM_ADDR_MST: next_rdata = {24'h00_0000, mst_reg & PDM_MST_WMASK};
                PDM_ADDR_SYS: next_rdata = {24'h00_0000, sys_reg};
                PDM_ADDR_STAT: next_rdata = {24'h00_0000, 2'h0, div_shift_o, mode_o};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_reg <= PDM_PWR_RESET;
            mst_reg <= PDM_MST_RESET;
            sys_reg <= PDM_SYS_RESET;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            pwr_reg <= next_pwr;
            mst_reg <= next_mst;
            sys_reg <= next_sys;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign ack_o = ack;
    assign dat_o = rdata;

    // ------------------------------------------------------------
    // Mode sequencing on sleep instruction
    // ------------------------------------------------------------
    pdm_mode_e mode;
    pdm_mode_e next_mode;
    logic [2:0] applied_div;
    logic [2:0] next_applied_div;
    logic [2:0] div_sh;
    logic [2:0] next_div_sh;
    logic kind_b;
    logic direct_b;
    logic stby_b;

    assign kind_b = pwr_reg[PDM_SLEEP_KIND_POS];
    assign direct_b = pwr_reg[PDM_DIRECT_POS];
    assign stby_b = sys_reg[PDM_STANDBY_POS];

    always_comb begin
        next_mode = mode;
        next_applied_div = applied_div;
        case (mode)
            PDM_MODE_ACTIVE: begin
                if (sleep_exec_i) begin
                    // Divide setting only latched here, never on the write itself
                    next_applied_div = pwr_reg[PDM_DIV_LSB +: 3];
                    if (direct_b) begin
                        // Direct change with kind set is undefined; stay active too
                        next_mode = PDM_MODE_ACTIVE;
                    end else if (stby_b) begin
                        next_mode = PDM_MODE_STANDBY;
                    end else if (kind_b) begin
                        next_mode = PDM_MODE_SUBSLEEP;
                    end else begin
                        next_mode = PDM_MODE_SLEEP;
                    end
                end
            end
            PDM_MODE_SLEEP,
            PDM_MODE_SUBSLEEP,
            PDM_MODE_STANDBY: begin
                if (wake_i) begin
                    next_mode = PDM_MODE_ACTIVE;
                end
            end
            default: next_mode = PDM_MODE_ACTIVE;
        endcase
        next_div_sh = pdm_div_shift(next_applied_div);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= PDM_MODE_ACTIVE;
            applied_div <= PDM_DIV_RESET;
            div_sh <= 3'h0;
        end else begin
            mode <= next_mode;
            applied_div <= next_applied_div;
            div_sh <= next_div_sh;
        end
    end

    assign mode_o = mode;
    assign div_shift_o = div_sh;

    // ------------------------------------------------------------
    // Clock divider enable: one pulse per 2^shift cycles
    // ------------------------------------------------------------
    logic [4:0] div_cnt;
    logic [4:0] next_div_cnt;
    logic div_en;
    logic next_div_en;
    logic [4:0] div_top;

    assign div_top = 5'((6'h01 << div_sh) - 6'h01);

    always_comb begin
        next_div_cnt = (div_cnt >= div_top) ? 5'h00 : 5'(div_cnt + 5'h01);
        next_div_en = (next_div_cnt == 5'h00);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= 5'h00;
            div_en <= 1'b1;
        end else begin
            div_cnt <= next_div_cnt;
            div_en <= next_div_en;
        end
    end

    assign clk_div_en_o = div_en;

    // ------------------------------------------------------------
    // Module clock enables; a held-off module keeps its state
    // ------------------------------------------------------------
    pdm_stop_s gate;
    pdm_stop_s next_gate;

    always_comb begin
        next_gate.i2c = !next_mst[PDM_STOP_I2C_POS];
        next_gate.serial = !next_mst[PDM_STOP_SER_POS];
        next_gate.adc = !next_mst[PDM_STOP_ADC_POS];
        // Oscillator-clocked watchdog ignores its stop bit
        next_gate.watchdog = next_sys[PDM_WDT_OSC_POS]
            || !next_mst[PDM_STOP_WDT_POS];
        next_gate.timer_w = !next_mst[PDM_STOP_TW_POS];
        next_gate.timer_v = !next_mst[PDM_STOP_TV_POS];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate <= '1;
        end else begin
            gate <= next_gate;
        end
    end

    assign clk_en_o = gate;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence sleep_req_s;
        mode == PDM_MODE_ACTIVE && sleep_exec_i;
    endsequence

    rsvd_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack && !we_i && adr_i == PDM_ADDR_PWR |-> (dat_o[6] == 1'b0 && dat_o[1:0] == 2'h0))
        else $error("power register reserved bits not zero");
    mst_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack && !we_i && adr_i == PDM_ADDR_MST |-> (dat_o[7] == 1'b0 && dat_o[0] == 1'b0))
        else $error("module-stop reserved bits not zero");
    standby_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_req_s and (!direct_b && stby_b) |=> mode == PDM_MODE_STANDBY)
        else $error("standby not entered");
    sleep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_req_s and (!direct_b && !stby_b && !kind_b) |=> mode == PDM_MODE_SLEEP)
        else $error("sleep not entered");
    subsleep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_req_s and (!direct_b && !stby_b && kind_b) |=> mode == PDM_MODE_SUBSLEEP)
        else $error("subsleep not entered");
    direct_stay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_req_s and direct_b |=> mode == PDM_MODE_ACTIVE)
        else $error("direct transition left active");
    div_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(sleep_exec_i && mode == PDM_MODE_ACTIVE) |=> $stable(applied_div))
        else $error("divide changed without sleep");
    div_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_req_s and (pwr_reg[4:2] == 3'h5) |=> ##1 div_shift_o == 3'h4)
        else $error("divide by 16 not decoded");
    i2c_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mst_reg[PDM_STOP_I2C_POS] |-> !clk_en_o.i2c)
        else $error("i2c runs while stopped");
    wdt_osc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sys_reg[PDM_WDT_OSC_POS] |-> clk_en_o.watchdog)
        else $error("oscillator watchdog stopped");
    tv_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mst_reg[PDM_STOP_TV_POS] |-> !clk_en_o.timer_v)
        else $error("timer V runs while stopped");
    ser_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mst_reg[PDM_STOP_SER_POS] |-> !clk_en_o.serial)
        else $error("serial runs while stopped");
    adc_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mst_reg[PDM_STOP_ADC_POS] |-> !clk_en_o.adc)
        else $error("converter runs while stopped");
    wdt_sys_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mst_reg[PDM_STOP_WDT_POS] && !sys_reg[PDM_WDT_OSC_POS] |-> !clk_en_o.watchdog)
        else $error("system-clock watchdog runs while stopped");
    tw_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mst_reg[PDM_STOP_TW_POS] |-> !clk_en_o.timer_w)
        else $error("timer W runs while stopped");
    i2c_resume_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !mst_reg[PDM_STOP_I2C_POS] |-> clk_en_o.i2c)
        else $error("i2c not resumed after clear");

    // ------------------------------------------------------------
    // Divide decode checks
    // ------------------------------------------------------------
    div_eight_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_req_s and (pwr_reg[4:2] == 3'h4) |=> div_shift_o == 3'h3)
        else $error("divide by 8 not decoded");
    div_thirty_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_req_s and (pwr_reg[4:2] == 3'h6) |=> div_shift_o == 3'h5)
        else $error("divide by 32 not decoded");
    div_undiv_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_req_s and !pwr_reg[4] |=> div_shift_o == 3'h0)
        else $error("undivided clock not decoded");

    // Cycles since the last divided-clock pulse; never beyond the slowest ratio
    logic [5:0] en_gap;
    logic [5:0] next_en_gap;

    always_comb begin
        next_en_gap = div_en ? 6'h00 : 6'(en_gap + 6'h01);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_gap <= 6'h00;
        end else begin
            en_gap <= next_en_gap;
        end
    end

    div_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |-> en_gap <= 6'h1F)
        else $error("divided clock pulse missing");

    // ------------------------------------------------------------
    // Mode and bus checks
    // ------------------------------------------------------------
    wake_active_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode != PDM_MODE_ACTIVE && wake_i |=> mode == PDM_MODE_ACTIVE)
        else $error("wake did not return to active");
    low_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode != PDM_MODE_ACTIVE && !wake_i |=> $stable(mode))
        else $error("low-power mode left without wake");
    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack |=> !ack)
        else $error("acknowledge longer than one cycle");
    dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ack |-> dat_o == 32'h0000_0000)
        else $error("read data not zero outside acknowledge");
    sys_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack && !we_i && adr_i == PDM_ADDR_SYS |-> dat_o[6:1] == 6'h00)
        else $error("system register unused bits not zero");
    // Status is captured one edge before the acknowledge shows it
    stat_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack && !we_i && adr_i == PDM_ADDR_STAT
        |-> dat_o[7:0] == {2'h0, $past(div_shift_o), $past(mode_o)})
        else $error("status read mismatch");

endmodule

// ==== tb_pdm_power_ctrl.sv ====
// Self-checking testbench for the power-down mode control block
`timescale 1ns/10ps
module testbench;
    import pdm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic we_i = 1'b0;
    logic [3:0] sel_i = 4'h0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic sleep_exec_i = 1'b0;
    logic wake_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o;
    pdm_mode_e mode_o;
    logic [2:0] div_shift_o;
    logic clk_div_en_o;
    pdm_stop_s clk_en_o;
    int bad_count = 0;
    int comparisons = 0;
    logic [31:0] rd;

    always #5 clk_i = ~clk_i;

    pdm_power_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .ack_o(ack_o), .sleep_exec_i(sleep_exec_i), .wake_i(wake_i), .mode_o(mode_o),
        .div_shift_o(div_shift_o), .clk_div_en_o(clk_div_en_o), .clk_en_o(clk_en_o));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic cycle; read data taken at the edge that samples ack, or at the 20th edge if ack never comes
    task automatic wb(input logic wr, input logic [3:0] adr, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= adr;
        sel_i <= 4'hF;
        dat_i <= {24'h0, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (n >= 20) check("ack", {31'h0, ack_o}, 32'h1);
    endtask

    task automatic rdchk(input string what, input logic [3:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 8'h00);
        check(what, rd, exp);
    endtask

    task automatic pulse(input bit slp);
        @(posedge clk_i);
        if (slp) sleep_exec_i <= 1'b1;
        else wake_i <= 1'b1;
        @(posedge clk_i);
        sleep_exec_i <= 1'b0;
        wake_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rdchk("pwr reset", PDM_ADDR_PWR, 32'h0);
        rdchk("mst reset", PDM_ADDR_MST, 32'h0);
        rdchk("stat reset", PDM_ADDR_STAT, 32'h0);
        check("clk_en reset", {26'h0, clk_en_o}, 32'h3F);
        wb(1'b1, PDM_ADDR_PWR, 8'hFF);
        rdchk("pwr reserved", PDM_ADDR_PWR, 32'hBC);
        wb(1'b1, PDM_ADDR_MST, 8'hFF);
        rdchk("mst reserved", PDM_ADDR_MST, 32'h7E);
        wb(1'b1, 4'h2, 8'hFF);
        rdchk("unmapped", 4'h2, 32'h0);
        wb(1'b1, PDM_ADDR_PWR, 8'h00);
        wb(1'b1, PDM_ADDR_MST, 8'h00);
        $display("test registers done");
    endtask

    task automatic t_stop;
        for (int i = 1; i <= 6; i++) begin
            wb(1'b1, PDM_ADDR_MST, 8'(1 << i));
            check("clk_en stop", {26'h0, clk_en_o}, 32'h3F ^ (32'h1 << (i - 1)));
        end
        wb(1'b1, PDM_ADDR_SYS, 8'h01);
        wb(1'b1, PDM_ADDR_MST, 8'h08);
        check("wdt on osc", {26'h0, clk_en_o}, 32'h3F);
        wb(1'b1, PDM_ADDR_SYS, 8'h00);
        check("wdt on sys", {26'h0, clk_en_o}, 32'h3B);
        wb(1'b1, PDM_ADDR_MST, 8'h00);
        check("clk_en resume", {26'h0, clk_en_o}, 32'h3F);
        $display("test module stop done");
    endtask

    task automatic t_div;
        logic [2:0] codes [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
        logic [2:0] shifts [5] = '{3'h3, 3'h4, 3'h5, 3'h0, 3'h0};
        logic [2:0] prev;
        int cnt;
        prev = 3'h0;
        for (int k = 0; k < 5; k++) begin
            wb(1'b1, PDM_ADDR_PWR, {3'h0, codes[k], 2'h0});
            repeat (3) @(posedge clk_i);
            #1;
            check("div before sleep", {29'h0, div_shift_o}, {29'h0, prev});
            pulse(1'b1);
            check("mode sleep", {29'h0, mode_o}, {29'h0, PDM_MODE_SLEEP});
            check("div applied", {29'h0, div_shift_o}, {29'h0, shifts[k]});
            pulse(1'b0);
            check("mode wake", {29'h0, mode_o}, {29'h0, PDM_MODE_ACTIVE});
            cnt = 0;
            repeat (64) begin
                @(posedge clk_i);
                #1;
                cnt += int'(clk_div_en_o === 1'b1);
            end
            check("div pulses", 32'(cnt), 32'(64 >> shifts[k]));
            prev = shifts[k];
        end
        $display("test divider done");
    endtask

    task automatic t_modes;
        wb(1'b1, PDM_ADDR_SYS, 8'h80);
        pulse(1'b1);
        check("mode standby", {29'h0, mode_o}, {29'h0, PDM_MODE_STANDBY});
        pulse(1'b0);
        wb(1'b1, PDM_ADDR_SYS, 8'h00);
        wb(1'b1, PDM_ADDR_PWR, 8'h80);
        pulse(1'b1);
        check("mode subsleep", {29'h0, mode_o}, {29'h0, PDM_MODE_SUBSLEEP});
        pulse(1'b0);
        wb(1'b1, PDM_ADDR_PWR, 8'h30);
        pulse(1'b1);
        check("mode direct", {29'h0, mode_o}, {29'h0, PDM_MODE_ACTIVE});
        check("div direct", {29'h0, div_shift_o}, 32'h3);
        rdchk("status", PDM_ADDR_STAT, 32'h18);
        $display("test modes done");
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this is far beyond it
    initial begin
        #200000;
        bad_count++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_stop();
        t_div();
        t_modes();
        final_report();
    end
endmodule
